// *** drhs_map.svh ***
// Register indexes, field positions, reset values and refresh timing counts
// What this block does
// R01: Column switch half or one clock after strobe
// R02: Power-up memory setup: one 256K bank defaults
// R03: Arbiter takes DMA request and tick rising edge
// R04: Hold ends, other requests: keep hold, hand grant
// R05: Drop CPU hold only when nobody requests
// R06: DMA grant on its own output
// R07: Coupled mode grants refresh via refresh strobe
// R08: Setup bit 7 selects coupled or decoupled
// R09: Coupled: low code drives both rates
// R10: Decoupled: board uses high code, slot low
// R11: Code zero every tick, others divide tick
// R12: Sleep uses CAS-before-RAS, else row-only refresh
// R13: Decoupled board refresh runs during slot cycles
// R14: Slot refresh pending stalls only slot accesses
// R15: Pointer against A23-A16 splits board and slot
// R16: Low pointer hides board DRAM up to A0000
// R17: Top two segments always select ROM
// R18: Out-of-range pointer acts like FFh
// R19: Pointer 0Ah to 0Fh acts like 10h
// R20: Pointer resets to FFh
// R21: Pointer write 00h-09h clears backfill enable
// R22: Backfill enable is expanded-enable bit 6
// R23: Row-only refresh drives and advances row counter
// R24: Simultaneous requests: refresh wins, DMA follows
`ifndef DRHS_MAP_SVH
`define DRHS_MAP_SVH
`define DRHS_IDX_MEM 8'h01
`define DRHS_IDX_REF 8'h06
`define DRHS_IDX_RAS 8'h07
`define DRHS_IDX_PTR 8'h1f
`define DRHS_IDX_EM1 8'h20
`define DRHS_MEM_RST 8'hc5
`define DRHS_REF_RST 8'h00
`define DRHS_RAS_RST 8'h80
`define DRHS_PTR_RST 8'hff
`define DRHS_EM1_RST 8'h00
`define DRHS_RF_DECUP 7
`define DRHS_RF_BRD 6:4
`define DRHS_RF_SLOT 2:0
`define DRHS_RAS_COLSW 7
`define DRHS_EM_EN 7
`define DRHS_EM_BF 6
`define DRHS_PTR_MIN 8'h04
`define DRHS_PTR_MAX 8'hed
`define DRHS_PTR_FULL 8'hff
`define DRHS_PTR_GAP_LO 8'h0a
`define DRHS_PTR_GAP_HI 8'h0f
`define DRHS_PTR_1M 8'h10
`define DRHS_PTR_HOLE_HI 8'h09
`define DRHS_ROM_SEG 8'hfe
`define DRHS_RF_RAS_LAST 3'h3
`endif

// *** drhs_pkg.sv ***
// Types shared by the refresh, hold and slot decode logic
package drhs_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] index;
        logic [7:0] wdata;
    } drhs_cfg_t;
    typedef struct packed {
        logic page_on;
        logic direct_map;
        logic [1:0] banks;
        logic [3:0] timing;
    } drhs_mem_t;
    typedef enum logic [1:0] {ARB_IDLE, ARB_WAIT, ARB_DMA, ARB_REF} drhs_arb_t;
    typedef enum logic [1:0] {RF_IDLE, RF_CAS, RF_RAS, RF_PRE} drhs_rf_t;
endpackage

// *** drhs_arb.sv ***
// Hold request arbiter between DMA and refresh
`timescale 1ns/1ps
module drhs_arb (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Requesters
    input wire logic dma_req,
    input wire logic ref_req,
    // CPU hold handshake
    input wire logic hold_ack,
    output logic cpu_hold_req,
    output logic dma_grant,
    output logic ref_grant
);
    import drhs_pkg::*;
    drhs_arb_t state;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ARB_IDLE;
        end else if (ce) begin
            unique case (state)
                // Wait for the CPU to drop its old acknowledge first
                ARB_IDLE: if ((dma_req || ref_req) && !hold_ack) state <= ARB_WAIT; // R03
                ARB_WAIT: if (hold_ack) begin
                    if (ref_req) state <= ARB_REF; // R24
                    else if (dma_req) state <= ARB_DMA;
                    else state <= ARB_IDLE;
                end
                ARB_DMA: if (!dma_req) state <= ref_req ? ARB_REF : ARB_IDLE; // R04
                ARB_REF: if (!ref_req) state <= dma_req ? ARB_DMA : ARB_IDLE; // R04
            endcase
        end
    end

    assign cpu_hold_req = (state != ARB_IDLE); // R05
    assign dma_grant = (state == ARB_DMA); // R06
    assign ref_grant = (state == ARB_REF);

    handoff_keep_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce) // R04
        (state == ARB_DMA && !dma_req && ref_req) |=> cpu_hold_req && ref_grant && !dma_grant)
        else $error("hold not handed from DMA to refresh");
    hold_release_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce) // R05
        ((dma_grant || ref_grant) && !dma_req && !ref_req) |=> !cpu_hold_req)
        else $error("hold kept with no requester");
    ref_first_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce) // R24
        (state == ARB_WAIT && hold_ack && ref_req && dma_req) |=> ref_grant)
        else $error("refresh not served first");
    handoff_c: cover property (@(posedge mclk) disable iff (!rst_n) dma_grant ##1 ref_grant);
endmodule

// *** drhs_ctl.sv ***
// Refresh control, hold arbitration, address select timing and slot boundary decode
`timescale 1ns/1ps
`include "drhs_map.svh"
module drhs_ctl #(
    parameter int ROW_W = 11
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Indexed configuration port
    input drhs_pkg::drhs_cfg_t cfg,
    output logic [7:0] cfg_rdata,
    output drhs_pkg::drhs_mem_t mem_setup,
    // CPU address decode
    input wire logic [23:0] cpu_addr,
    output logic board_sel,
    output logic slot_sel,
    output logic rom_sel,
    // Hold handshake
    input wire logic dma_hold_req,
    input wire logic cpu_hold_ack,
    output logic cpu_hold_req,
    output logic dma_hold_grant,
    output logic refresh_n,
    // Refresh timing and slot bus
    input wire logic refresh_timer_tick,
    input wire logic sleep_mode,
    input wire logic slot_cycle_active,
    input wire logic slot_access_req,
    input wire logic slot_refresh_done,
    output logic slot_refresh_req,
    output logic cpu_stall,
    // DRAM side
    input wire logic mem_row_req,
    input wire logic [ROW_W-1:0] row_addr,
    input wire logic [ROW_W-1:0] col_addr,
    output logic bank_row_strobe_n,
    output logic refresh_cas_n,
    output logic mux_switch_select,
    output logic [ROW_W-1:0] dram_addr_lines,
    output logic dram_addr_drive
);
    import drhs_pkg::*;

    logic [7:0] refresh_setup;
    logic [7:0] ras_timing;
    logic [7:0] slot_boundary_pointer;
    logic [7:0] expanded_map_enable_one;
    logic decup;
    logic tick_q;
    logic tick_rise;
    logic [1:0][2:0] div_code;
    logic [1:0][2:0] div_cnt;
    logic [1:0] div_hit;
    logic brd_pend;
    logic slot_pend;
    logic ref_grant;
    logic rf_start;
    logic rf_done;
    logic rf_busy;
    logic cbr;
    logic next_cbr;
    logic [2:0] rf_cnt;
    logic [ROW_W-1:0] rf_row;
    drhs_rf_t rf_state;
    drhs_rf_t next_rf;
    logic row_cpu;
    logic next_cpu_ras;
    logic ras_d1;
    logic ras_h;
    logic [7:0] seg;

    function automatic logic idx_hit(input drhs_cfg_t c, input logic [7:0] idx);
        return c.index == idx;
    endfunction

    // Pointer as the decoder really uses it
    function automatic logic [7:0] eff_ptr(input logic [7:0] p);
        if (p < `DRHS_PTR_MIN || p > `DRHS_PTR_MAX) return `DRHS_PTR_FULL; // R18
        if (p >= `DRHS_PTR_GAP_LO && p <= `DRHS_PTR_GAP_HI) return `DRHS_PTR_1M; // R19
        return p;
    endfunction

    // Configuration registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_setup <= `DRHS_MEM_RST; // R02
            refresh_setup <= `DRHS_REF_RST;
            ras_timing <= `DRHS_RAS_RST;
            slot_boundary_pointer <= `DRHS_PTR_RST; // R20
            expanded_map_enable_one <= `DRHS_EM1_RST;
        end else if (ce) begin
            if (cfg.wr && idx_hit(cfg, `DRHS_IDX_MEM)) mem_setup <= cfg.wdata;
            if (cfg.wr && idx_hit(cfg, `DRHS_IDX_REF)) refresh_setup <= cfg.wdata;
            if (cfg.wr && idx_hit(cfg, `DRHS_IDX_RAS)) ras_timing <= cfg.wdata;
            if (cfg.wr && idx_hit(cfg, `DRHS_IDX_PTR)) slot_boundary_pointer <= cfg.wdata;
            if (cfg.wr && idx_hit(cfg, `DRHS_IDX_EM1)) expanded_map_enable_one <= cfg.wdata;
            // A pointer write below 640K clears backfill; a later expanded-enable write can set it again
            if (cfg.wr && idx_hit(cfg, `DRHS_IDX_PTR) && cfg.wdata <= `DRHS_PTR_HOLE_HI) begin
                expanded_map_enable_one[`DRHS_EM_BF] <= 1'b0; // R21 R22
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= 8'h00;
        end else if (ce && cfg.rd) begin
            case (cfg.index)
                `DRHS_IDX_MEM: cfg_rdata <= mem_setup;
                `DRHS_IDX_REF: cfg_rdata <= refresh_setup;
                `DRHS_IDX_RAS: cfg_rdata <= ras_timing;
                `DRHS_IDX_PTR: cfg_rdata <= slot_boundary_pointer;
                `DRHS_IDX_EM1: cfg_rdata <= expanded_map_enable_one;
                default: cfg_rdata <= 8'h00;
            endcase
        end
    end

    // Slot boundary decode, registered
    assign seg = cpu_addr[23:16];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rom_sel <= 1'b0;
            slot_sel <= 1'b0;
            board_sel <= 1'b0;
        end else if (ce) begin
            rom_sel <= seg >= `DRHS_ROM_SEG; // R17
            slot_sel <= seg < `DRHS_ROM_SEG && seg >= eff_ptr(slot_boundary_pointer); // R15
            // Board DRAM above a low pointer is simply never selected
            board_sel <= seg < `DRHS_ROM_SEG && seg < eff_ptr(slot_boundary_pointer); // R15 R16
        end
    end

    // Refresh rate division
    assign decup = refresh_setup[`DRHS_RF_DECUP]; // R08
    assign tick_rise = refresh_timer_tick && !tick_q; // R03
    assign div_code[0] = decup ? refresh_setup[`DRHS_RF_BRD] : refresh_setup[`DRHS_RF_SLOT]; // R09 R10
    assign div_code[1] = refresh_setup[`DRHS_RF_SLOT]; // R10

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) tick_q <= 1'b0;
        else if (ce) tick_q <= refresh_timer_tick;
    end

    genvar g;
    for (g = 0; g < 2; g++) begin : g_div
        assign div_hit[g] = tick_rise && div_cnt[g] == div_code[g]; // R11
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) div_cnt[g] <= 3'h0;
            else if (ce && tick_rise) div_cnt[g] <= div_hit[g] ? 3'h0 : div_cnt[g] + 3'h1; // R11
        end
    end

    // Pending refreshes; a new request beats the clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) brd_pend <= 1'b0;
        else if (ce && div_hit[0]) brd_pend <= 1'b1;
        else if (ce && rf_done) brd_pend <= 1'b0;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) slot_pend <= 1'b0;
        else if (ce && decup && div_hit[1]) slot_pend <= 1'b1; // R10
        else if (ce && (slot_refresh_done || !decup)) slot_pend <= 1'b0;
    end

    assign slot_refresh_req = slot_pend;
    // The CPU runs on unless it wants the slot bus meanwhile
    assign cpu_stall = slot_pend && slot_access_req; // R14

    drhs_arb u_arb (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .dma_req(dma_hold_req),
        .ref_req(brd_pend && !decup),
        .hold_ack(cpu_hold_ack),
        .cpu_hold_req(cpu_hold_req),
        .dma_grant(dma_hold_grant),
        .ref_grant(ref_grant)
    );

    assign refresh_n = !ref_grant; // R07

    // Refresh cycle sequencer
    assign rf_start = rf_state == RF_IDLE && brd_pend && (decup ? slot_cycle_active : ref_grant); // R07 R13
    assign rf_done = rf_state == RF_PRE;
    assign rf_busy = rf_state != RF_IDLE;
    assign next_cbr = (rf_state == RF_IDLE) ? sleep_mode : cbr;

    always_comb begin
        next_rf = rf_state;
        unique case (rf_state)
            RF_IDLE: if (rf_start) next_rf = sleep_mode ? RF_CAS : RF_RAS; // R12
            RF_CAS: next_rf = RF_RAS;
            RF_RAS: if (rf_cnt == `DRHS_RF_RAS_LAST) next_rf = RF_PRE;
            RF_PRE: next_rf = RF_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rf_state <= RF_IDLE;
            cbr <= 1'b0;
            rf_cnt <= 3'h0;
        end else if (ce) begin
            rf_state <= next_rf;
            cbr <= next_cbr;
            rf_cnt <= (rf_state == RF_RAS) ? rf_cnt + 3'h1 : 3'h0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) rf_row <= '0;
        else if (ce && rf_done && !cbr) rf_row <= rf_row + ROW_W'(1); // R23
    end

    // DRAM strobes, registered
    assign next_cpu_ras = mem_row_req && rf_state == RF_IDLE && !rf_start;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bank_row_strobe_n <= 1'b1;
            refresh_cas_n <= 1'b1;
            row_cpu <= 1'b0;
        end else if (ce) begin
            bank_row_strobe_n <= !(next_cpu_ras || next_rf == RF_RAS);
            refresh_cas_n <= !(next_rf == RF_CAS || (next_rf == RF_RAS && next_cbr)); // R12
            row_cpu <= next_cpu_ras;
        end
    end

    // Column switch: full-clock path on the rising edge, half-clock path on the falling edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) ras_d1 <= 1'b0;
        else if (ce) ras_d1 <= !bank_row_strobe_n && row_cpu;
    end

    always_ff @(negedge mclk or negedge rst_n) begin
        if (!rst_n) ras_h <= 1'b0;
        else if (ce) ras_h <= !bank_row_strobe_n && row_cpu;
    end

    assign mux_switch_select = ras_timing[`DRHS_RAS_COLSW] ? ras_d1 : ras_h; // R01
    // Row counter only for row-only refresh; CBR leaves the lines undriven
    assign dram_addr_lines = rf_busy ? rf_row : (mux_switch_select ? col_addr : row_addr); // R23
    assign dram_addr_drive = !(rf_busy && cbr); // R12

    ptr_reset_a: assert property (@(posedge mclk) $rose(rst_n) |-> slot_boundary_pointer == `DRHS_PTR_RST) // R20
        else $error("pointer reset value wrong");
    bf_clear_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce) // R21
        (cfg.wr && cfg.index == `DRHS_IDX_PTR && cfg.wdata <= `DRHS_PTR_HOLE_HI)
        |=> !expanded_map_enable_one[`DRHS_EM_BF])
        else $error("backfill enable not cleared");
    rom_top_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce) // R17
        (seg >= `DRHS_ROM_SEG) |=> rom_sel && !slot_sel && !board_sel)
        else $error("top segment not ROM");
    ptr_range_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce) // R18
        ((slot_boundary_pointer < `DRHS_PTR_MIN || slot_boundary_pointer > `DRHS_PTR_MAX)
        && seg < `DRHS_ROM_SEG) |=> board_sel && !slot_sel)
        else $error("out-of-range pointer not treated as FFh");
    ptr_gap_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce) // R19
        (slot_boundary_pointer >= `DRHS_PTR_GAP_LO && slot_boundary_pointer <= `DRHS_PTR_GAP_HI
        && seg == `DRHS_PTR_GAP_HI) |=> board_sel)
        else $error("gap pointer not treated as 10h");
    ref_ack_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce) // R07
        !refresh_n |-> !decup && cpu_hold_req && !dma_hold_grant)
        else $error("refresh acknowledge outside coupled hold");
    coupled_slot_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce) // R09
        (!decup) [*2] |-> !slot_refresh_req)
        else $error("slot refresh request in coupled mode");
    cbr_cycle_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce) // R12
        (rf_start && sleep_mode) |=> !refresh_cas_n && bank_row_strobe_n
        ##1 !refresh_cas_n && !bank_row_strobe_n && !dram_addr_drive)
        else $error("CAS-before-RAS sequence wrong");
    col_full_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce) // R01
        ($fell(bank_row_strobe_n) && row_cpu && ras_timing[`DRHS_RAS_COLSW])
        |-> !mux_switch_select ##1 mux_switch_select)
        else $error("full-clock column switch mistimed");
    col_half_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce) // R01
        ($fell(bank_row_strobe_n) && row_cpu && !ras_timing[`DRHS_RAS_COLSW]) |-> mux_switch_select)
        else $error("half-clock column switch mistimed");

    decup_ref_c: cover property (@(posedge mclk) disable iff (!rst_n) decup && rf_start && slot_cycle_active);
    row_only_c: cover property (@(posedge mclk) disable iff (!rst_n) rf_done && !cbr);
    stall_c: cover property (@(posedge mclk) disable iff (!rst_n) cpu_stall ##[1:20] slot_refresh_done);
endmodule

// *** drhs_cpu_model.sv ***
// CPU hold handshake and bus controller slot refresh model
`timescale 1ns/1ps
module drhs_cpu_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Hold handshake
    input wire logic [3:0] ack_dly,
    input wire logic cpu_hold_req,
    output logic cpu_hold_ack,
    // Slot refresh
    input wire logic slot_refresh_req,
    output logic slot_refresh_done
);
    logic [3:0] wait_cnt;
    logic [2:0] slot_cnt;

    // Ack and its release both lag the request, as a CPU first finishes its own bus cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt <= 4'h0;
            cpu_hold_ack <= 1'b0;
        end else if (cpu_hold_req == cpu_hold_ack) begin
            wait_cnt <= 4'h0;
        end else if (wait_cnt >= ack_dly) begin
            wait_cnt <= 4'h0;
            cpu_hold_ack <= cpu_hold_req;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end

    // One-cycle completion pulse a few cycles after a slot refresh is asked for
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            slot_cnt <= 3'h0;
            slot_refresh_done <= 1'b0;
        end else begin
            slot_refresh_done <= (slot_cnt == 3'h4);
            slot_cnt <= (slot_refresh_req && slot_cnt != 3'h4) ? slot_cnt + 3'h1 : 3'h0;
        end
    end
endmodule

// *** tb.sv ***
// Self-checking bench for refresh, hold arbitration and slot decode
`timescale 1ns/1ps
module tb;
    import drhs_pkg::*;
    logic mclk = 1'b0, rst_n = 1'b0, tick = 1'b0, sleep = 1'b0, slot_act = 1'b0, slot_acc = 1'b0;
    logic dma_req = 1'b0, row_req = 1'b0, ce = 1'b1, hack, sdone;
    logic [3:0] ack_dly = 4'h2;
    logic [23:0] addr = 24'h0;
    logic [7:0] rdata, d;
    drhs_cfg_t cfg = '0;
    drhs_mem_t mem_setup;
    logic board_sel, slot_sel, rom_sel, cpu_hold_req, dma_hold_grant, refresh_n, slot_refresh_req;
    logic cpu_stall, bank_row_strobe_n, refresh_cas_n, mux_switch_select, dram_addr_drive;
    logic [10:0] dram_addr_lines, r0;
    int failures = 0, comparisons = 0, n, h, s, i;
    logic [18:0] dec[12] = '{{8'hff,8'h80,3'h4}, {8'h10,8'h0f,3'h4}, {8'h10,8'h10,3'h2}, {8'h0c,8'h0f,3'h4},
        {8'h0c,8'h10,3'h2}, {8'h05,8'h08,3'h2}, {8'h05,8'h04,3'h4}, {8'h03,8'h80,3'h4}, {8'hee,8'hef,3'h4},
        {8'hed,8'hed,3'h2}, {8'h10,8'hfe,3'h1}, {8'h10,8'hff,3'h1}};
    logic [15:0] rst_tab[6] = '{16'h01c5, 16'h0600, 16'h0780, 16'h1fff, 16'h2000, 16'h3300};

    always #5 mclk = ~mclk;

    drhs_ctl #(.ROW_W(11)) uut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .cfg(cfg), .cfg_rdata(rdata),
        .mem_setup(mem_setup), .cpu_addr(addr), .board_sel(board_sel), .slot_sel(slot_sel), .rom_sel(rom_sel),
        .dma_hold_req(dma_req), .cpu_hold_ack(hack), .cpu_hold_req(cpu_hold_req), .dma_hold_grant(dma_hold_grant),
        .refresh_n(refresh_n), .refresh_timer_tick(tick), .sleep_mode(sleep), .slot_cycle_active(slot_act),
        .slot_access_req(slot_acc), .slot_refresh_done(sdone), .slot_refresh_req(slot_refresh_req),
        .cpu_stall(cpu_stall), .mem_row_req(row_req), .row_addr(11'h2aa), .col_addr(11'h555),
        .bank_row_strobe_n(bank_row_strobe_n), .refresh_cas_n(refresh_cas_n),
        .mux_switch_select(mux_switch_select), .dram_addr_lines(dram_addr_lines), .dram_addr_drive(dram_addr_drive));

    drhs_cpu_model partner (.mclk(mclk), .rst_n(rst_n), .ack_dly(ack_dly), .cpu_hold_req(cpu_hold_req),
        .cpu_hold_ack(hack), .slot_refresh_req(slot_refresh_req), .slot_refresh_done(sdone));

    task final_report;
        if (failures == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask

    task wr(input logic [7:0] idx, input logic [7:0] v);
        @(negedge mclk);
        cfg = '{wr: 1'b1, rd: 1'b0, index: idx, wdata: v};
        @(negedge mclk);
        cfg.wr = 1'b0;
    endtask

    task rd(input logic [7:0] idx, output logic [7:0] v);
        @(negedge mclk);
        cfg = '{wr: 1'b0, rd: 1'b1, index: idx, wdata: 8'h00};
        @(negedge mclk);
        cfg.rd = 1'b0;
        v = rdata;
    endtask

    function automatic logic sg(input int k);
        case (k)
            0: return cpu_hold_req;
            1: return dma_hold_grant;
            2: return refresh_n;
            3: return bank_row_strobe_n;
            default: return refresh_cas_n;
        endcase
    endfunction

    // Bounded wait for one output to reach a level
    task wt(input int k, input logic v);
        int j;
        for (j = 0; j < 300; j++) begin
            @(negedge mclk);
            if (sg(k) === v)
                return;
        end
        failures++;
        $display("wrong value at %0t: wait on output %0d timed out", $time, k);
        final_report();
    endtask

    task tick_p;
        @(negedge mclk);
        tick = 1'b1;
        @(negedge mclk);
        tick = 1'b0;
    endtask

    // Counts tick windows that saw a board refresh, plus any hold or stall seen
    task cnt_ref(input int nt);
        int t, seen;
        n = 0;
        h = 0;
        s = 0;
        for (t = 0; t < nt; t++) begin
            tick_p();
            seen = 0;
            repeat (30) begin
                @(negedge mclk);
                if (bank_row_strobe_n === 1'b0) seen = 1;
                if (cpu_hold_req === 1'b1) h = 1;
                if (cpu_stall === 1'b1) s = 1;
            end
            n += seen;
        end
    endtask

    task colsw(input logic half);
        int j;
        @(negedge mclk);
        row_req = 1'b1;
        for (j = 0; j < 20 && bank_row_strobe_n !== 1'b0; j++) begin
            @(posedge mclk);
            #2;
        end
        check({bank_row_strobe_n, mux_switch_select, dram_addr_lines}, {2'b00, 11'h2aa});
        #5;
        check(mux_switch_select, half);
        @(posedge mclk);
        #2;
        check({mux_switch_select, dram_addr_lines}, {1'b1, 11'h555});
        @(negedge mclk);
        row_req = 1'b0;
        cyc(4);
    endtask

    initial begin
        cyc(20);
        rst_n = 1'b1;
        check(mem_setup, 8'hc5);
        wr(8'h33, 8'h55);
        for (i = 0; i < 6; i++) begin
            rd(rst_tab[i][15:8], d);
            check(d, rst_tab[i][7:0]);
        end
        for (i = 0; i < 12; i++) begin
            wr(8'h1f, dec[i][18:11]);
            addr = {dec[i][10:3], 16'h1234};
            cyc(2);
            check({board_sel, slot_sel, rom_sel}, dec[i][2:0]);
        end
        // Backfill bit cleared only by pointer writes 00h to 09h
        wr(8'h20, 8'hc0);
        wr(8'h1f, 8'h0a);
        rd(8'h20, d);
        check(d, 8'hc0);
        wr(8'h1f, 8'h09);
        rd(8'h20, d);
        check(d, 8'h80);
        wr(8'h01, 8'h3a);
        rd(8'h01, d);
        check({d, mem_setup}, 16'h3a3a);
        // Enable low: the pointer write must not land
        ce = 1'b0;
        wr(8'h1f, 8'h40);
        ce = 1'b1;
        rd(8'h1f, d);
        check(d, 8'h09);
        colsw(1'b0);
        wr(8'h07, 8'h00);
        colsw(1'b1);
        // DMA holds, refresh tick arrives, hold is handed over without release
        dma_req = 1'b1;
        wt(0, 1'b1);
        wt(1, 1'b1);
        tick_p();
        cyc(6);
        check({dma_hold_grant, refresh_n, cpu_hold_req}, 3'h7);
        dma_req = 1'b0;
        wt(2, 1'b0);
        check({cpu_hold_req, dma_hold_grant}, 2'h2);
        wt(3, 1'b0);
        r0 = dram_addr_lines;
        check(dram_addr_drive, 1'b1);
        wt(0, 1'b0);
        check(refresh_n, 1'b1);
        // Both requests at once: refresh first, then DMA
        ack_dly = 4'h5;
        dma_req = 1'b1;
        tick_p();
        wt(2, 1'b0);
        check(dma_hold_grant, 1'b0);
        wt(3, 1'b0);
        check(dram_addr_lines, r0 + 11'h1);
        wt(1, 1'b1);
        check({refresh_n, cpu_hold_req}, 2'h3);
        dma_req = 1'b0;
        wt(0, 1'b0);
        // Sleep refresh is column-first with address lines released
        sleep = 1'b1;
        tick_p();
        wt(4, 1'b0);
        check({dram_addr_drive, bank_row_strobe_n}, 2'h1);
        wt(0, 1'b0);
        sleep = 1'b0;
        // Coupled: low code 2 divides by three, high field ignored
        wr(8'h06, 8'h72);
        cnt_ref(6);
        check({n[7:0], h[7:0]}, 16'h0201);
        // Decoupled: board refresh waits for a slot cycle and takes no hold
        wr(8'h06, 8'h80);
        cnt_ref(1);
        check(n[7:0], 8'h00);
        slot_act = 1'b1;
        wt(3, 1'b0);
        check({cpu_hold_req, refresh_n}, 2'h1);
        wr(8'h06, 8'h90);
        slot_acc = 1'b1;
        cnt_ref(4);
        check({n[7:0], h[7:0], s[7:0]}, 24'h020001);
        check({slot_refresh_req, cpu_stall}, 2'h0);
        final_report();
    end
endmodule
